// *** hw/adcr_pkg.sv ***
// Summary of operation
// - Converter runs only while enable bit set
// - Writing one to bits 7 and 6 starts conversion if already enabled
// - Bit 6 reads one when ready or done
// - Codes 0000-0111 select port B inputs 0-7
// - Codes 1000-1010 select port A pins 3,4,0
// - Code 1111 selects bandgap; others reserved
// - Mode bits 3-1 divide clock by 2^n
// - Result high holds result bits 11-4
// - High register bit 7 is result MSB
// - Result low bits 7-4 hold bits 3-0
// - Result registers are read-only
package adcr_pkg;
    // ----------------------------------------
    // Register word indices and byte addresses
    // ----------------------------------------
    localparam logic [7:0] CTRL_IDX     = 8'h20;
    localparam logic [7:0] MODE_IDX     = 8'h21;
    localparam logic [7:0] RES_HI_IDX   = 8'h22;
    localparam logic [7:0] RES_LO_IDX   = 8'h23;
    localparam logic [7:0] IRQ_STAT_IDX = 8'h24;
    localparam logic [7:0] IRQ_MASK_IDX = 8'h25;
    localparam logic [9:0] CTRL_ADDR     = {CTRL_IDX, 2'b00};
    localparam logic [9:0] MODE_ADDR     = {MODE_IDX, 2'b00};
    localparam logic [9:0] RES_HI_ADDR   = {RES_HI_IDX, 2'b00};
    localparam logic [9:0] RES_LO_ADDR   = {RES_LO_IDX, 2'b00};
    localparam logic [9:0] IRQ_STAT_ADDR = {IRQ_STAT_IDX, 2'b00};
    localparam logic [9:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int EN_BIT    = 7;
    localparam int START_BIT = 6;
    localparam int CH_LSB    = 2;
    localparam int DIV_LSB   = 1;
    localparam int DONE_IRQ  = 0;
    // ----------------------------------------
    // Channel codes, reset values, divider limit, result width and states
    // ----------------------------------------
    localparam logic [3:0] CH_PA3      = 4'h8;
    localparam logic [3:0] CH_PA4      = 4'h9;
    localparam logic [3:0] CH_PA0      = 4'hA;
    localparam logic [3:0] CH_BANDGAP  = 4'hF;
    localparam logic [3:0] CH_RESET    = 4'h0;
    localparam logic [2:0] DIV_RESET   = 3'h0;
    localparam logic [11:0] RES_RESET  = 12'h000;
    localparam logic [7:0] DIV_CNT_MAX = 8'h7F;
    localparam int RES_BITS = 12;
    typedef enum logic [1:0] {ADCR_IDLE, ADCR_CONV, ADCR_DONE} adcr_state_t;
endpackage

// *** hw/adcr_top.sv ***
`timescale 1ns/1ps
module adcr_top #(
    parameter int RES_W = 12
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    input  wire logic             wb_cyc_in,
    input  wire logic             wb_stb_in,
    input  wire logic             wb_we_in,
    input  wire logic [9:0]       wb_adr_in,
    input  wire logic [3:0]       wb_sel_in,
    input  wire logic [31:0]      wb_dat_in,
    output logic      [31:0]      wb_dat_out,
    output logic                  wb_ack_out,
    output logic                  irq_out,
    // Analog core side
    output logic                  core_power_out,
    output logic                  core_clk_en_out,
    output logic                  core_start_out,
    output logic      [3:0]       core_chan_out,
    output logic                  core_bandgap_sel_out,
    input  wire logic             core_done_in,
    input  wire logic [RES_W-1:0] core_result_in
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic                     enable_ff;
    logic [3:0]               chan_ff;
    logic [2:0]               div_ff;
    logic [11:0]              result_ff;
    logic                     irq_stat_ff;
    logic                     irq_mask_ff;
    logic [7:0]               div_cnt_ff;
    adcr_pkg::adcr_state_t    state_ff;
    logic                     wr_req;
    logic                     rd_req;
    logic                     start_req;
    logic                     ready;
    logic                     done_evt;
    logic [7:0]               div_mask;
    logic [3:0]               nxt_chan;
    logic [31:0]              nxt_dat;

    assign wr_req = wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_sel_in[0];
    assign rd_req = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in;
    assign start_req = wr_req && (wb_adr_in == adcr_pkg::CTRL_ADDR)
                       && wb_dat_in[adcr_pkg::START_BIT]
                       && wb_dat_in[adcr_pkg::EN_BIT] && enable_ff;
    assign ready = (state_ff != adcr_pkg::ADCR_CONV);
    assign done_evt = (state_ff == adcr_pkg::ADCR_CONV) && core_done_in;
    // Mask of 2^div - 1: zero for divide-by-1, so the enable then stays high
    assign div_mask = 8'((16'h0001 << div_ff) - 16'h0001);

    // Channel as it will stand after this edge, so the start pulse sees it
    always_comb begin
        nxt_chan = chan_ff;
        if (wr_req && wb_adr_in == adcr_pkg::CTRL_ADDR && ready) begin
            nxt_chan = wb_dat_in[adcr_pkg::CH_LSB +: 4];
        end
    end

    // ----------------------------------------
    // Bus acknowledge, one cycle after the strobe
    // ----------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
        end
    end

    always_comb begin
        nxt_dat = 32'h0000_0000;
        if (wb_adr_in == adcr_pkg::CTRL_ADDR) begin
            nxt_dat[7:0] = {enable_ff, ready, chan_ff, 2'b00};
        end else if (wb_adr_in == adcr_pkg::MODE_ADDR) begin
            nxt_dat[7:0] = {4'h0, div_ff, 1'b0};
        end else if (wb_adr_in == adcr_pkg::RES_HI_ADDR) begin
            nxt_dat[7:0] = result_ff[11:4];
        end else if (wb_adr_in == adcr_pkg::RES_LO_ADDR) begin
            nxt_dat[7:0] = {result_ff[3:0], 4'h0};
        end else if (wb_adr_in == adcr_pkg::IRQ_STAT_ADDR) begin
            nxt_dat[7:0] = {7'h00, irq_stat_ff};
        end else if (wb_adr_in == adcr_pkg::IRQ_MASK_ADDR) begin
            nxt_dat[7:0] = {7'h00, irq_mask_ff};
        end else begin
            nxt_dat = 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wb_dat_out <= 32'h0000_0000;
        end else if (rd_req) begin
            wb_dat_out <= nxt_dat;
        end
    end

    // ----------------------------------------
    // Control and mode registers
    // ----------------------------------------
    // Reserved bits are dropped; software must write them as zero
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            enable_ff <= 1'b0;
            chan_ff   <= adcr_pkg::CH_RESET;
            div_ff    <= adcr_pkg::DIV_RESET;
        end else if (wr_req && wb_adr_in == adcr_pkg::CTRL_ADDR) begin
            enable_ff <= wb_dat_in[adcr_pkg::EN_BIT];
            // Channel frozen mid-conversion so the sample stays coherent
            if (ready) begin
                chan_ff <= wb_dat_in[adcr_pkg::CH_LSB +: 4];
            end
        end else if (wr_req && wb_adr_in == adcr_pkg::MODE_ADDR) begin
            div_ff <= wb_dat_in[adcr_pkg::DIV_LSB +: 3];
        end
    end

    // ----------------------------------------
    // Conversion sequence
    // ----------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff       <= adcr_pkg::ADCR_IDLE;
            core_start_out <= 1'b0;
        end else begin
            core_start_out <= 1'b0;
            case (state_ff)
                adcr_pkg::ADCR_IDLE, adcr_pkg::ADCR_DONE: begin
                    if (start_req) begin
                        state_ff       <= adcr_pkg::ADCR_CONV;
                        core_start_out <= 1'b1;
                    end
                end
                adcr_pkg::ADCR_CONV: begin
                    if (!enable_ff) begin
                        state_ff <= adcr_pkg::ADCR_IDLE;
                    end else if (core_done_in) begin
                        state_ff <= adcr_pkg::ADCR_DONE;
                    end
                end
                default: begin
                    state_ff <= adcr_pkg::ADCR_IDLE;
                end
            endcase
        end
    end

    // Result has no bus write path at all
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            result_ff <= adcr_pkg::RES_RESET;
        end else if (done_evt && enable_ff) begin
            // MSB-aligned whatever the core width
            result_ff <= 12'({core_result_in, 12'h000} >> RES_W);
        end
    end

    // ----------------------------------------
    // Converter clock divider
    // ----------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_cnt_ff      <= 8'h00;
            core_clk_en_out <= 1'b0;
        end else if (!enable_ff) begin
            div_cnt_ff      <= 8'h00;
            core_clk_en_out <= 1'b0;
        end else begin
            div_cnt_ff      <= (div_cnt_ff & div_mask) == div_mask ? 8'h00 : 8'(div_cnt_ff + 8'h01);
            core_clk_en_out <= (div_cnt_ff & div_mask) == div_mask;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            core_power_out       <= 1'b0;
            core_chan_out        <= adcr_pkg::CH_RESET;
            core_bandgap_sel_out <= 1'b0;
        end else begin
            core_power_out       <= enable_ff;
            core_chan_out        <= nxt_chan;
            core_bandgap_sel_out <= nxt_chan == adcr_pkg::CH_BANDGAP;
        end
    end

    // ----------------------------------------
    // Interrupt: set wins over write-one clear
    // ----------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_stat_ff <= 1'b0;
            irq_mask_ff <= 1'b0;
            irq_out     <= 1'b0;
        end else begin
            if (done_evt && enable_ff) begin
                irq_stat_ff <= 1'b1;
            end else if (wr_req && wb_adr_in == adcr_pkg::IRQ_STAT_ADDR
                         && wb_dat_in[adcr_pkg::DONE_IRQ]) begin
                irq_stat_ff <= 1'b0;
            end
            if (wr_req && wb_adr_in == adcr_pkg::IRQ_MASK_ADDR) begin
                irq_mask_ff <= wb_dat_in[adcr_pkg::DONE_IRQ];
            end
            irq_out <= irq_stat_ff && irq_mask_ff;
        end
    end
endmodule

// *** sim/adcr_core_mdl.sv ***
`timescale 1ns/1ps
module adcr_core_mdl #(
    parameter int DLY = 20
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        start_in,
    input  wire logic [11:0] val_in,
    output logic             done_out,
    output logic      [11:0] res_out
);
    int cnt_ff;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_ff <= 0;
        end else if (start_in) begin
            cnt_ff <= DLY;
        end else if (cnt_ff != 0) begin
            cnt_ff <= cnt_ff - 1;
        end
    end
    // Inverted outside done, so a stale capture cannot match
    assign done_out = cnt_ff == 1;
    assign res_out  = done_out ? val_in : ~val_in;
endmodule

// *** sim/adcr_chk.sv ***
`timescale 1ns/1ps
module adcr_chk (
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic [9:0]  wb_adr_in,
    input wire logic [3:0]  wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic        wb_ack_out,
    input wire logic        core_power_out,
    input wire logic        core_start_out,
    input wire logic [3:0]  core_chan_out,
    input wire logic        core_bandgap_sel_out,
    input wire logic        core_done_in
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    logic       bsy_ff;
    logic [3:0] chan_ff;
    wire logic  ctl = wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_sel_in[0]
                      && wb_adr_in == adcr_pkg::CTRL_ADDR;
    wire logic  idle = ctl && !bsy_ff && !core_start_out;
    // Busy mirror lags the design by a cycle; bench keeps writes spaced
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bsy_ff <= 1'b0;
        end else begin
            bsy_ff <= core_start_out || (bsy_ff && !core_done_in && core_power_out);
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (ctl) begin
            chan_ff <= wb_dat_in[5:2];
        end
    end
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held too long");
    ack_resp_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("request not acknowledged");
    start_pwr_a: assert property (core_start_out |-> core_power_out)
        else $error("start while unpowered");
    start_go_a: assert property (idle && wb_dat_in[7:6] == 2'b11 && core_power_out
        |-> ##[1:2] core_start_out) else $error("start write ignored");
    start_ign_a: assert property (ctl && !wb_dat_in[7] |=> !core_start_out [*2])
        else $error("start while disabled");
    bandgap_sel_a: assert property (core_bandgap_sel_out
        == (core_chan_out == adcr_pkg::CH_BANDGAP)) else $error("bandgap select wrong");
    chan_route_a: assert property (idle |-> ##2 core_chan_out == chan_ff)
        else $error("channel not routed");
    lo_pad_a: assert property (wb_ack_out && !wb_we_in && wb_adr_in == adcr_pkg::RES_LO_ADDR
        |-> wb_dat_out[3:0] == 4'h0) else $error("result low pad not zero");
    hi_zero_a: assert property (wb_ack_out && !wb_we_in |-> wb_dat_out[31:8] == 24'h0)
        else $error("upper read bits not zero");
endmodule
bind adcr_top adcr_chk u_chk (.*);

// *** sim/adcr_top_tb.sv ***
`timescale 1ns/1ps
module adcr_top_tb;
    logic        core_clk_in, rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, irq_out;
    logic        core_power_out, core_clk_en_out, core_start_out, core_bandgap_sel_out;
    logic        core_done_in;
    logic [9:0]  wb_adr_in;
    logic [3:0]  wb_sel_in, core_chan_out;
    logic [31:0] wb_dat_in, wb_dat_out, rd;
    logic [11:0] core_result_in, val;
    logic [3:0]  chs [6] = '{4'h0, 4'h7, 4'h8, 4'h9, 4'hA, 4'hF};
    int          n_mismatch = 0, compares = 0, k, t, n;
    adcr_top dut (.*);
    adcr_core_mdl u_core (.clk_in(core_clk_in), .rst_in(rst_in), .start_in(core_start_out),
        .val_in(val), .done_out(core_done_in), .res_out(core_result_in));
    initial begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end
    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int c = 0;
        @(posedge core_clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= w;
        wb_adr_in <= a;
        wb_dat_in <= d;
        do begin
            @(posedge core_clk_in);
            c++;
        end while (wb_ack_out !== 1'b1 && c < 20);
        rd = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        if (c >= 20) n_mismatch++;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [9:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic end_of_test;
        $display("Compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} = '0;
        wb_sel_in = 4'hF;
        val = 12'h000;
        rst_in = 1'b1;
        repeat (3) @(posedge core_clk_in);
        rst_in <= 1'b0;
        rdc(adcr_pkg::CTRL_ADDR, 32'h40);
        wb(1'b1, adcr_pkg::CTRL_ADDR, 32'h40);
        rdc(adcr_pkg::CTRL_ADDR, 32'h40);
        $display("Test disabled start done");
        for (k = 0; k < 6; k++) begin
            val = {chs[k], ~chs[k], chs[k] ^ 4'h3};
            wb(1'b1, adcr_pkg::CTRL_ADDR, {24'h0, 2'b10, chs[k], 2'b00});
            wb(1'b1, adcr_pkg::CTRL_ADDR, {24'h0, 2'b11, chs[k], 2'b00});
            rdc(adcr_pkg::CTRL_ADDR, {24'h0, 2'b10, chs[k], 2'b00});
            chk({28'h0, core_chan_out}, {28'h0, chs[k]});
            chk({31'h0, core_bandgap_sel_out}, {31'h0, chs[k] == 4'hF});
            t = 0;
            do begin
                wb(1'b0, adcr_pkg::CTRL_ADDR, 32'h0);
                t++;
            end while (rd[6] !== 1'b1 && t < 50);
            chk(rd, {24'h0, 2'b11, chs[k], 2'b00});
            rdc(adcr_pkg::RES_HI_ADDR, {24'h0, val[11:4]});
            rdc(adcr_pkg::RES_LO_ADDR, {24'h0, val[3:0], 4'h0});
        end
        wb(1'b1, adcr_pkg::RES_HI_ADDR, 32'hFF);
        wb(1'b1, adcr_pkg::RES_LO_ADDR, 32'hFF);
        rdc(adcr_pkg::RES_HI_ADDR, {24'h0, val[11:4]});
        rdc(adcr_pkg::RES_LO_ADDR, {24'h0, val[3:0], 4'h0});
        wb(1'b1, 10'h3FC, 32'hFF);
        rdc(10'h3FC, 32'h0);
        $display("Test conversions done");
        rdc(adcr_pkg::IRQ_STAT_ADDR, 32'h1);
        chk({31'h0, irq_out}, 32'h0);
        wb(1'b1, adcr_pkg::IRQ_MASK_ADDR, 32'h1);
        repeat (2) @(posedge core_clk_in);
        chk({31'h0, irq_out}, 32'h1);
        wb(1'b1, adcr_pkg::IRQ_STAT_ADDR, 32'h1);
        repeat (2) @(posedge core_clk_in);
        chk({31'h0, irq_out}, 32'h0);
        rdc(adcr_pkg::IRQ_STAT_ADDR, 32'h0);
        $display("Test interrupt done");
        for (k = 0; k < 8; k++) begin
            wb(1'b1, adcr_pkg::MODE_ADDR, 32'(k << 1));
            rdc(adcr_pkg::MODE_ADDR, 32'(k << 1));
            repeat (256) @(posedge core_clk_in);
            n = 0;
            repeat (256) begin
                @(posedge core_clk_in);
                if (core_clk_en_out === 1'b1) n++;
            end
            chk(n, 256 >> k);
        end
        wb(1'b1, adcr_pkg::CTRL_ADDR, 32'h0);
        repeat (2) @(posedge core_clk_in);
        chk({31'h0, core_power_out}, 32'h0);
        $display("Test divider and disable done");
        end_of_test();
    end
endmodule
